/* File: rtl/cps_pkg.sv */
// Types of the cable port status bank
package cps_pkg;
	typedef logic [2:0] cps_speed_t;
	typedef enum logic [1:0] {
		CPS_MODE_BILINGUAL = 2'h0,
		CPS_MODE_BETA_ONLY = 2'h1,
		CPS_MODE_LEGACY    = 2'h2
	} cps_mode_t;
	typedef enum logic [1:0] {
		CPS_BUS_IDLE = 2'h0,
		CPS_BUS_ACK  = 2'h1
	} cps_bus_t;
endpackage

/* File: rtl/cps_port_status.sv */
// Per-port status and control bank of a cable PHY, Avalon-MM slave
// What this block does
// - dc-link flag follows the port's dc connect-detect sense.
// - Speed codes: 0 S100 .. 5 S3200, 6 reserved.
// - Written limit above capability stores the capability code.
// - Limit applied only on new beta connection or on beta-only port.
// - Bilingual port holds S400 and ignores limit writes.
// - Reset loads limit with the port's capability.
// - Plug-present flag always reads 1.
// - Capability field reports the port's top beta speed.
// - Failed speed negotiation or sync sets unreliable flag.
// - Writing 1 clears unreliable flag; writing 0 does nothing.
// - Beta-operation flag is 1 only while port runs in beta mode.
// - Connected, receive-valid and not beta shows legacy-active status.
// - Error counter counts invalid codewords, saturating at 255.
// - Reading the error counter clears it, local or remote read.
// - Sleep flag reads 1 while port sleeps.
// - Port enters sleep only when sleep is enabled for it.
// - Connected bit set after 341 ms stable; hard reset clears it.
// - Receive-valid needs continuous valid signal, false on tones only.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`include "cps_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module cps_port_status
	import cps_pkg::*;
#(
	parameter int  NPORTS       = 3,
	parameter int  DEBOUNCE_CYC = `CPS_DEBOUNCE_CYC,
	parameter logic [3*NPORTS-1:0] PORT_CAP  = {NPORTS{`CPS_SPD_S400}},
	parameter logic [2*NPORTS-1:0] PORT_MODE = {NPORTS{2'h0}}
)(
	input  wire logic                  sys_clk_i,       // System clock
	input  wire logic                  rst_n_i,         // Async reset
	input  wire logic [`CPS_ADDR_W-1:0] avs_address,    // Word address
	input  wire logic                  avs_read,        // Read request
	input  wire logic                  avs_write,       // Write request
	input  wire logic [31:0]           avs_writedata,   // Write data
	input  wire logic [3:0]            avs_byteenable,  // Byte lanes
	output logic      [31:0]           avs_readdata,    // Read data
	output logic                       avs_waitrequest, // Stall
	input  wire logic                  remote_rd_i,     // Remote read pulse
	input  wire logic [1:0]            remote_port_i,   // Remote read port
	input  wire logic [NPORTS-1:0]     dc_sense_i,      // Dc connect pin
	input  wire logic [NPORTS-1:0]     conn_sense_i,    // Raw connection
	input  wire logic [NPORTS-1:0]     sig_valid_i,     // Valid signal
	input  wire logic [NPORTS-1:0]     tone_only_i,     // Only tones seen
	input  wire logic [NPORTS-1:0]     beta_active_i,   // Beta mode running
	input  wire logic [NPORTS-1:0]     beta_new_conn_i, // New beta link
	input  wire logic [NPORTS-1:0]     neg_fail_i,      // Speed neg failed
	input  wire logic [NPORTS-1:0]     sync_fail_i,     // Sync failed
	input  wire logic [NPORTS-1:0]     bad_code_i,      // Invalid codeword
	input  wire logic [NPORTS-1:0]     sleep_req_i,     // Sleep request
	output logic      [NPORTS-1:0]     sleep_o,         // Port sleeping
	output logic      [3*NPORTS-1:0]   train_speed_o    // Applied speed
);

	localparam int CW = $clog2(DEBOUNCE_CYC + 1);

	initial
	begin
		if (NPORTS < 1 || NPORTS > 4)
			$error("NPORTS must be 1 to 4");
		if (DEBOUNCE_CYC < 1)
			$error("DEBOUNCE_CYC must be positive");
	end

	typedef struct packed {
		cps_bus_t                  bus;
		logic [31:0]               rdata;
		logic [1:0]                sel;
		logic [NPORTS-1:0]         dc_s1, dc_s2;
		logic [NPORTS-1:0]         cn_s1, cn_s2;
		logic [NPORTS-1:0]         sv_s1, sv_s2;
		logic [NPORTS-1:0]         tn_s1, tn_s2;
		logic [NPORTS-1:0]         connected;
		logic [NPORTS-1:0]         rx_valid;
		logic [NPORTS-1:0][CW-1:0] deb;
		logic [NPORTS-1:0][2:0]    limit;
		logic [NPORTS-1:0][2:0]    applied;
		logic [NPORTS-1:0]         unreliable;
		logic [NPORTS-1:0][7:0]    errcnt;
		logic [NPORTS-1:0]         sleep_en;
		logic [NPORTS-1:0]         sleeping;
	} cps_state_t;

	cps_state_t st_r;
	cps_state_t st_nxt;

	function automatic logic [2:0] cap_of(input int p);
		cap_of = PORT_CAP[3*p +: 3];
	endfunction

	function automatic logic [31:0] status_of(input cps_state_t s, input int p);
		logic [31:0] w;
		w = 32'h0;
		w[`CPS_ST_DC_LINK]    = s.dc_s2[p];
		w[`CPS_ST_PLUG]       = 1'b1;
		w[`CPS_ST_UNRELIABLE] = s.unreliable[p];
		w[`CPS_ST_BETA_OP]    = beta_active_i[p] & s.connected[p];
		w[`CPS_ST_CONNECTED]  = s.connected[p];
		w[`CPS_ST_RX_VALID]   = s.rx_valid[p];
		w[`CPS_ST_LEGACY_ACT] = s.connected[p] & s.rx_valid[p]
			& ~(beta_active_i[p] & s.connected[p]);
		w[`CPS_ST_SLEEP]      = s.sleeping[p];
		w[`CPS_ST_SPD_LSB +: 3] = s.limit[p];
		w[`CPS_ST_CAP_LSB +: 3] = cap_of(p);
		return w;
	endfunction

	always_comb
	begin
		logic        wr;
		logic        rd;
		logic [2:0]  wspd;
		int          p;
		st_nxt = st_r;
		wr   = 1'b0;
		rd   = 1'b0;
		wspd = avs_writedata[2:0];
		p    = int'(st_r.sel);
		st_nxt.dc_s1 = dc_sense_i;
		st_nxt.dc_s2 = st_r.dc_s1;
		st_nxt.cn_s1 = conn_sense_i;
		st_nxt.cn_s2 = st_r.cn_s1;
		st_nxt.sv_s1 = sig_valid_i;
		st_nxt.sv_s2 = st_r.sv_s1;
		st_nxt.tn_s1 = tone_only_i;
		st_nxt.tn_s2 = st_r.tn_s1;
		unique case (st_r.bus)
			CPS_BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					st_nxt.bus = CPS_BUS_ACK;
					wr = avs_write;
					rd = avs_read;
				end
			end
			CPS_BUS_ACK:
				st_nxt.bus = CPS_BUS_IDLE;
		endcase
		for (int i = 0; i < NPORTS; i++)
		begin
			// Debounce of the raw connection
			if (!st_r.cn_s2[i])
			begin
				st_nxt.deb[i] = '0;
				st_nxt.connected[i] = 1'b0;
			end
			else if (st_r.deb[i] == CW'(DEBOUNCE_CYC))
				st_nxt.connected[i] = 1'b1;
			else
				st_nxt.deb[i] = st_r.deb[i] + CW'(1);
			st_nxt.rx_valid[i] = st_r.sv_s2[i] & ~st_r.tn_s2[i]
				& st_r.connected[i];
			// Speed applied to training
			if (PORT_MODE[2*i +: 2] == 2'(CPS_MODE_BILINGUAL))
				st_nxt.applied[i] = `CPS_SPD_S400;
			else if (PORT_MODE[2*i +: 2] == 2'(CPS_MODE_BETA_ONLY)
				|| beta_new_conn_i[i])
				st_nxt.applied[i] = st_r.limit[i];
			if (sync_fail_i[i] || neg_fail_i[i])
				st_nxt.unreliable[i] = 1'b1;
			else if (wr && p == i && avs_address == `CPS_OFS_STATUS
				&& avs_byteenable[0]
				&& avs_writedata[`CPS_ST_UNRELIABLE])
				st_nxt.unreliable[i] = 1'b0;
			if ((rd && p == i && avs_address == `CPS_OFS_ERRCNT)
				|| (remote_rd_i && int'(remote_port_i) == i))
				st_nxt.errcnt[i] = 8'h00;
			if (bad_code_i[i] && st_r.errcnt[i] != `CPS_ERR_MAX)
				st_nxt.errcnt[i] = st_nxt.errcnt[i] + 8'h01;
			st_nxt.sleeping[i] = sleep_req_i[i] & st_r.sleep_en[i];
		end
		if (wr && avs_byteenable[0])
		begin
			unique case (avs_address)
				`CPS_OFS_SELECT:
					if (int'(avs_writedata[1:0]) < NPORTS)
						st_nxt.sel = avs_writedata[1:0];
				`CPS_OFS_SPEED:
					if (PORT_MODE[2*p +: 2] != 2'(CPS_MODE_BILINGUAL))
					begin
						if (wspd > cap_of(p))
							st_nxt.limit[p] = cap_of(p);
						else
							st_nxt.limit[p] = wspd;
					end
				`CPS_OFS_SLEEPEN:
					st_nxt.sleep_en[p] = avs_writedata[0];
				default:
					st_nxt.sel = st_r.sel;
			endcase
		end
		if (rd)
		begin
			unique case (avs_address)
				`CPS_OFS_SELECT:  st_nxt.rdata = {30'h0, st_r.sel};
				`CPS_OFS_STATUS:  st_nxt.rdata = status_of(st_r, p);
				`CPS_OFS_SPEED:   st_nxt.rdata = {29'h0, st_r.limit[p]};
				`CPS_OFS_ERRCNT:  st_nxt.rdata = {24'h0, st_r.errcnt[p]};
				`CPS_OFS_SLEEPEN: st_nxt.rdata = {31'h0, st_r.sleep_en[p]};
				default:          st_nxt.rdata = `CPS_UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r <= '0;
			for (int i = 0; i < NPORTS; i++)
			begin
				st_r.limit[i]   <= PORT_CAP[3*i +: 3];
				st_r.applied[i] <= PORT_CAP[3*i +: 3];
			end
		end
		else
			st_r <= st_nxt;
	end

	always_comb
	begin
		avs_readdata    = st_r.rdata;
		// Stall from state only; high while idle is legal
		avs_waitrequest = st_r.bus != CPS_BUS_ACK;
		sleep_o         = st_r.sleeping;
		for (int i = 0; i < NPORTS; i++)
			train_speed_o[3*i +: 3] = st_r.applied[i];
	end

endmodule // cps_port_status

`default_nettype wire

/* File: rtl/cps_regs.svh */
// Register map, field positions and timing constants of the port status bank
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

`define CPS_ADDR_W          4
`define CPS_OFS_SELECT      4'h0
`define CPS_OFS_STATUS      4'h1
`define CPS_OFS_SPEED       4'h2
`define CPS_OFS_ERRCNT      4'h3
`define CPS_OFS_SLEEPEN     4'h4

`define CPS_ST_DC_LINK      0
`define CPS_ST_PLUG         1
`define CPS_ST_UNRELIABLE   2
`define CPS_ST_BETA_OP      3
`define CPS_ST_CONNECTED    4
`define CPS_ST_RX_VALID     5
`define CPS_ST_LEGACY_ACT   6
`define CPS_ST_SLEEP        7
`define CPS_ST_SPD_LSB      8
`define CPS_ST_CAP_LSB      12

`define CPS_SPD_S100        3'h0
`define CPS_SPD_S400        3'h2
`define CPS_SPD_S3200       3'h5
`define CPS_ERR_MAX         8'hff
`define CPS_UNMAPPED_DATA   32'hdeadbeef

`define CPS_CLK_HZ          10000000
`define CPS_DEBOUNCE_MS     341
`define CPS_DEBOUNCE_CYC    ((`CPS_CLK_HZ / 1000) * `CPS_DEBOUNCE_MS)

`endif

/* File: verif/cps_peer_model.sv */
// Cable-side peer port model
`timescale 1ns/10ps
`default_nettype none
module cps_peer_model
	import cps_pkg::*;
(
	input  wire logic       sys_clk_i, // Clock
	input  wire logic [2:0] plug_i,    // Cable in
	input  wire logic [2:0] beta_i,    // Peer in beta
	output logic      [2:0] dc_o,      // Dc detect
	output logic      [2:0] tone_o,    // Tones only
	output logic      [2:0] valid_o,   // Signal valid
	output logic      [2:0] beta_o     // Beta running
);
	logic [2:0] s1, s2, s3;
	// Tones for three cycles before a valid signal
	always_ff @(posedge sys_clk_i)
	begin
		s1 <= plug_i;
		s2 <= s1 & plug_i;
		s3 <= s2 & plug_i;
	end
	assign dc_o = plug_i;
	assign valid_o = s3 & plug_i;
	assign tone_o = plug_i & ~s3;
	assign beta_o = beta_i & valid_o;
endmodule // cps_peer_model
`default_nettype wire

/* File: verif/cps_port_status_asserts.sv */
// Port-level assertions of the cable port status bank
`timescale 1ns/10ps
`default_nettype none
module cps_port_status_asserts
	import cps_pkg::*;
#(parameter int NPORTS = 3)
(
	input wire logic [0:0]          sys_clk_i,       // Clock
	input wire logic [0:0]          rst_n_i,         // Reset
	input wire logic [3:0]          avs_address,     // Address
	input wire logic [0:0]          avs_read,        // Read
	input wire logic [31:0]         avs_readdata,    // Data
	input wire logic [0:0]          avs_waitrequest, // Stall
	input wire logic [NPORTS-1:0]   sleep_req_i,     // Sleep ask
	input wire logic [NPORTS-1:0]   sleep_o,         // Sleeping
	input wire logic [3*NPORTS-1:0] train_speed_o    // Speed
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Status word being answered
	wire        st = avs_read && !avs_waitrequest && avs_address == 4'h1;
	wire [31:0] d  = avs_readdata;
	a_plug_one: assert property (st |-> d[1])
		else $error("plug flag read 0");
	a_limit_cap: assert property (st |-> d[10:8] <= d[14:12])
		else $error("limit above capability");
	a_cap_legal: assert property (st |-> d[14:12] <= 3'h5)
		else $error("capability code reserved");
	a_legacy_act: assert property (st |-> d[6] == (d[4] && d[5] && !d[3]))
		else $error("legacy active wrong");
	a_beta_conn: assert property (st && d[3] |-> d[4])
		else $error("beta flag without link");
	a_bili_fixed: assert property (train_speed_o[2:0] == 3'h2)
		else $error("bilingual speed moved");
	a_sleep_gate: assert property ((sleep_o & ~$past(sleep_req_i)) == '0)
		else $error("sleep without request");
	a_sleep_drop: assert property ($fell(sleep_req_i[0]) |=> !sleep_o[0])
		else $error("sleep flag stuck");
endmodule // cps_port_status_asserts
bind cps_port_status cps_port_status_asserts #(.NPORTS(NPORTS)) u_sva (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
	.avs_read(avs_read), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .sleep_req_i(sleep_req_i),
	.sleep_o(sleep_o), .train_speed_o(train_speed_o));
`default_nettype wire

/* File: verif/test_cable_port_status_fields.sv */
// Bench of the cable port status bank
`timescale 1ns/10ps
`default_nettype none
module test_cable_port_status_fields
	import cps_pkg::*;
;
	logic        clk, rst_n, rd, wr, wt, rrd;
	logic [3:0]  adr;
	logic [31:0] wd, rdat, q;
	logic [1:0]  rport;
	logic [2:0]  plug, beta, nf, sf, bad, slp, dc, tone, sv, ba, so, nc;
	logic [8:0]  spd;
	int          err_total = 0, num_checks = 0;
	cps_port_status #(.NPORTS(3), .DEBOUNCE_CYC(20),
		.PORT_CAP({3'h3, 3'h5, 3'h2}), .PORT_MODE({2'h2, 2'h1, 2'h0})) DUT (
		.sys_clk_i(clk), .rst_n_i(rst_n), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata(rdat), .avs_waitrequest(wt), .remote_rd_i(rrd),
		.remote_port_i(rport), .dc_sense_i(dc), .conn_sense_i(dc),
		.sig_valid_i(sv), .tone_only_i(tone), .beta_active_i(ba),
		.beta_new_conn_i(nc), .neg_fail_i(nf), .sync_fail_i(sf),
		.bad_code_i(bad), .sleep_req_i(slp), .sleep_o(so), .train_speed_o(spd));
	cps_peer_model u_peer (.sys_clk_i(clk), .plug_i(plug), .beta_i(beta),
		.dc_o(dc), .tone_o(tone), .valid_o(sv), .beta_o(ba));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic hang;
		err_total++;
		stop_test();
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		{rd, wr, adr, wd} <= {!w, w, a, v};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wt !== 1'b0 && n < 50);
		q = rdat;
		{rd, wr} <= 2'b00;
		if (n >= 50)
			hang();
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] m, e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic s_reset;
		rc(4'h1, 32'h77ff, 32'h2202);
		rc(4'h9, 32'hffffffff, 32'hdeadbeef);
	endtask
	task automatic s_speed;
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b1, 4'h2, 32'h7);
		rc(4'h2, 32'h7, 32'h5);
		bus(1'b1, 4'h2, 32'h1);
		rc(4'h2, 32'h7, 32'h1);
		chk(32'(spd), 32'h0ca);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h2, 32'h1);
		rc(4'h2, 32'h7, 32'h2);
		bus(1'b1, 4'h0, 32'h2);
		bus(1'b1, 4'h2, 32'h1);
		chk(32'(spd[8:6]), 32'h3);
		nc <= 3'h4;
		tick(1);
		nc <= 3'h0;
		tick(1);
		chk(32'(spd[8:6]), 32'h1);
	endtask
	task automatic s_link;
		int n;
		n = 0;
		plug <= 3'h6;
		beta <= 3'h2;
		bus(1'b1, 4'h0, 32'h2);
		rc(4'h1, 32'h10, 32'h0);
		while (q[4] !== 1'b1 && n < 30)
		begin
			rc(4'h1, 32'h0, 32'h0);
			n++;
		end
		if (n >= 30)
			hang();
		rc(4'h1, 32'hff, 32'h73);
		bus(1'b1, 4'h0, 32'h1);
		rc(4'h1, 32'hfb, 32'h3b);
	endtask
	task automatic s_unrel;
		nf <= 3'h2;
		tick(1);
		nf <= 3'h0;
		rc(4'h1, 32'h4, 32'h4);
		bus(1'b1, 4'h1, 32'h0);
		rc(4'h1, 32'h4, 32'h4);
		bus(1'b1, 4'h1, 32'h4);
		rc(4'h1, 32'h4, 32'h0);
		sf <= 3'h2;
		tick(1);
		sf <= 3'h0;
		rc(4'h1, 32'h4, 32'h4);
	endtask
	task automatic s_err;
		bad <= 3'h2;
		tick(3);
		bad <= 3'h0;
		rc(4'h3, 32'hffffffff, 32'h3);
		rc(4'h3, 32'hffffffff, 32'h0);
		bad <= 3'h2;
		tick(300);
		bad <= 3'h0;
		rc(4'h3, 32'hffffffff, 32'hff);
		bad <= 3'h2;
		tick(2);
		{bad, rrd, rport} <= {3'h0, 1'b1, 2'h1};
		tick(1);
		rrd <= 1'b0;
		rc(4'h3, 32'hffffffff, 32'h0);
	endtask
	task automatic s_sleep;
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h4, 32'h0);
		slp <= 3'h1;
		tick(2);
		chk(32'(so), 32'h0);
		bus(1'b1, 4'h4, 32'h1);
		tick(1);
		chk(32'(so), 32'h1);
		rc(4'h1, 32'h80, 32'h80);
		slp <= 3'h0;
		tick(2);
	endtask
	initial
	begin
		{rd, wr, rrd, adr, wd, rport, plug, beta, nf, sf, bad, slp, nc} = '0;
		rst_n = 1'b0;
		tick(16);
		rst_n <= 1'b1;
		s_reset();
		s_speed();
		s_link();
		s_unrel();
		s_err();
		s_sleep();
		stop_test();
	end
endmodule // test_cable_port_status_fields
`default_nettype wire
